// ### ctl_model.sv
`default_nettype none
module ctl_model #(
	parameter int RATE = 2
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            rd_go,
	input  wire logic [7:0]      rd_len,
	input  wire logic [1:0]      hs_go,
	input  wire logic [1:0]      hs_ch,
	input  wire logic [3:0]      seq_busy,
	output logic      [RATE-1:0] rdata_en_full,
	output logic      [31:0]     cap_rdata,
	output var logic  [3:0]      ctl_refresh_done,
	output var logic  [3:0]      ctl_long_idle,
	output var logic  [15:0]     cyc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left_r;
	// enable on every slot through the burst
	assign rdata_en_full = {RATE{left_r != 8'h00}};
	// memory data differs every cycle, never holds
	assign cap_rdata = {16'hda7a, cyc};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= 8'h00;
			cyc <= 16'h0000;
			ctl_refresh_done <= 4'h0;
			ctl_long_idle <= 4'h0;
		end else begin
			cyc <= cyc + 16'h0001;
			if (left_r != 8'h00)
				left_r <= left_r - 8'h01;
			else if (rd_go && seq_busy == 4'h0)
				left_r <= rd_len;
			ctl_refresh_done <= (ctl_refresh_done | (4'(hs_go[0]) << hs_ch)) & ~seq_busy;
			ctl_long_idle <= (ctl_long_idle | (4'(hs_go[1]) << hs_ch)) & ~seq_busy;
		end
	end
endmodule
`default_nettype wire

// ### phy_cal_monitor.sv
`default_nettype none
module phy_cal_monitor #(
	parameter int RATE        = 2,
	parameter int DQ          = 32,
	parameter int LINK_CYCLES = 4,
	parameter int FIFO_CYCLES = 4,
	parameter int TRK_CYCLES  = 3,
	parameter bit SINGLE_BIT  = 1'b0,
	parameter bit PHY_ONLY    = 1'b0
) (
	input wire logic                             pclk,
	input wire logic                             presetn,
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pready,
	input wire logic                             pslverr,
	input wire logic [7:0]                       paddr,
	input wire logic [RATE-1:0]                  rdata_en_full,
	input wire logic [DQ-1:0]                    rdata,
	input wire logic [RATE-1:0]                  rdata_valid,
	input wire logic                             cal_success,
	input wire logic                             cal_fail,
	input wire logic                             cal_req,
	input wire logic [phy_cal_pkg::LAT_W-1:0]    rlat,
	input wire logic [phy_cal_pkg::TRACK_CH-1:0] seq_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] run_cnt;
	logic [15:0] busy_cnt;

	// ==========================================
	// cycles spent calibrating, cycles channel 0 busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cnt <= 16'h0000;
			busy_cnt <= 16'h0000;
		end else begin
			run_cnt <= (cal_req || cal_success || cal_fail) ? 16'h0000 : run_cnt + 16'h0001;
			busy_cnt <= seq_busy[0] ? busy_cnt + 16'h0001 : 16'h0000;
		end
	end

	// ==========================================
	// checks
	a_never_both: assert property (!(cal_success && cal_fail))
		else $error("success and fail high together");
	a_recal_clears: assert property (cal_req |=> !cal_success && !cal_fail)
		else $error("status not cleared by recalibration");
	a_cal_duration: assert property ($rose(cal_success || cal_fail)
		|-> run_cnt >= LINK_CYCLES + FIFO_CYCLES)
		else $error("calibration ended too early");
	a_busy_length: assert property (disable iff (!presetn || cal_req) $fell(seq_busy[0])
		|-> busy_cnt == TRK_CYCLES)
		else $error("tracking busy length wrong");
	a_busy_needs_cal: assert property ((|seq_busy) |-> cal_success)
		else $error("tracking without calibration");
	a_valid_gated: assert property ((|rdata_valid) |-> cal_success)
		else $error("read valid before calibration");
	a_rlat_zero: assert property (!PHY_ONLY && rlat == 6'h00 && $past(rlat) == 6'h00 && $past(cal_success)
		|-> rdata_valid == (SINGLE_BIT ? {RATE{$past(rdata_en_full[0])}} : $past(rdata_en_full)))
		else $error("read valid not one cycle after enable");
	a_rdata_hold: assert property (rdata_valid == '0 |-> $stable(rdata))
		else $error("read data moved without valid");
	a_err_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access phase");
	a_err_decode: assert property (pready |-> pslverr == (paddr > phy_cal_pkg::IRQ_MASK_OFS || paddr[1:0] != 2'h0))
		else $error("error flag does not match address");
	c_pass: cover property ($rose(cal_success));
	c_fail: cover property ($rose(cal_fail));
	c_busy: cover property ($rose(seq_busy[0]));
	c_valid: cover property (&rdata_valid);
endmodule

bind phy_read_cal_tracking_port phy_cal_monitor #(
	.RATE(RATE), .DQ(DQ), .LINK_CYCLES(LINK_CYCLES), .FIFO_CYCLES(FIFO_CYCLES), .TRK_CYCLES(TRK_CYCLES),
	.SINGLE_BIT(SINGLE_BIT), .PHY_ONLY(PHY_ONLY)
) i_phy_cal_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.paddr(paddr),
	.rdata_en_full(rdata_en_full), .rdata(rdata), .rdata_valid(rdata_valid), .cal_success(cal_success),
	.cal_fail(cal_fail), .cal_req(cal_req), .rlat(rlat), .seq_busy(seq_busy)
);
`default_nettype wire

// ### phy_cal_pkg.sv
`default_nettype none
package phy_cal_pkg;

	// ==========================================
	// register offsets
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] STATUS_OFS    = 8'h04;
	localparam logic [7:0] WLAT_OFS      = 8'h08;
	localparam logic [7:0] RLAT_OFS      = 8'h0c;
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;

	// ==========================================
	// field positions
	localparam int CTRL_TRACK_EN_BIT    = 0;
	localparam int CTRL_FAIL_INJECT_BIT = 1;
	localparam int CTRL_SOFT_RECAL_BIT  = 2;
	localparam int STAT_SUCCESS_BIT     = 0;
	localparam int STAT_FAIL_BIT        = 1;
	localparam int STAT_RUNNING_BIT     = 2;
	localparam int STAT_BUSY_LSB        = 4;
	localparam int IRQ_PASS_BIT         = 0;
	localparam int IRQ_FAIL_BIT         = 1;
	localparam int IRQ_TRACK_BIT        = 2;
	localparam int IRQ_W                = 3;

	// ==========================================
	// reset values
	localparam logic [2:0] CTRL_RST     = 3'h0;
	localparam logic [5:0] LAT_RST      = 6'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

	// ==========================================
	// widths and timing counts
	localparam int LAT_W              = 6;
	localparam int LAT_MAX            = 63;
	localparam int TRACK_CH           = 4;
	localparam int CNT_W              = 16;
	localparam int CAL_LINK_CYCLES    = 64;
	localparam int CAL_FIFO_CYCLES    = 32;
	localparam int TRACK_CYCLES       = 16;
	localparam int TRACK_INTERVAL     = 4000;

	typedef enum logic [2:0] {
		SEQ_RESET,
		SEQ_LINK,
		SEQ_FIFO,
		SEQ_PASS,
		SEQ_FAIL
	} seq_state_t;

endpackage
`default_nettype wire

// ### phy_read_cal_tracking_port.sv
// The APB register port and the placing of the registers were decided locally.
`default_nettype none
// Operation
// - one enable bit may serve all slots when reads align to even cycles
// - read data counts only in slots flagged by read valid
// - read valid marks each valid slot, optionally as one shared bit
// - success status rises once calibration finishes well
// - failure status rises when calibration fails
// - recalibration request holds sequencer in its reset state
// - releasing the request starts a complete new calibration
// - write latency reported per group, 0 to 63 cycles
// - shared write latency needs only the low six bits
// - read latency reported, 0 to 63 cycles; rlat output held at zero in phy-only build
// - with tracking on, sequencer periodically borrows interface for strobe alignment
// - busy handshake stays high while tracking runs
// - sequencer calibrates link then fifos and reports outcome
module phy_read_cal_tracking_port #(
	parameter int RATE        = 2,
	parameter int DQ          = 32,
	parameter int GROUPS      = 4,
	parameter bit SINGLE_BIT  = 1'b0,
	parameter bit PHY_ONLY    = 1'b0,
	parameter int LINK_CYCLES = phy_cal_pkg::CAL_LINK_CYCLES,
	parameter int FIFO_CYCLES = phy_cal_pkg::CAL_FIFO_CYCLES,
	parameter int TRK_CYCLES  = phy_cal_pkg::TRACK_CYCLES,
	parameter int TRK_PERIOD  = phy_cal_pkg::TRACK_INTERVAL
) (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	input  wire logic                             ce,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [7:0]                       paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	output logic                                  irq,
	input  wire logic [RATE-1:0]                  rdata_en_full,
	input  wire logic [DQ-1:0]                    cap_rdata,
	output logic      [DQ-1:0]                    rdata,
	output logic      [RATE-1:0]                  rdata_valid,
	output logic                                  cal_success,
	output logic                                  cal_fail,
	input  wire logic                             cal_req,
	output logic      [GROUPS*6-1:0]              wlat,
	output logic      [phy_cal_pkg::LAT_W-1:0]    rlat,
	input  wire logic [phy_cal_pkg::TRACK_CH-1:0] ctl_refresh_done,
	output logic      [phy_cal_pkg::TRACK_CH-1:0] seq_busy,
	input  wire logic [phy_cal_pkg::TRACK_CH-1:0] ctl_long_idle
);
	localparam int WL = GROUPS * phy_cal_pkg::LAT_W;
	localparam int CW = phy_cal_pkg::CNT_W;

	if (GROUPS < 1 || GROUPS > 5) begin : g_bad_groups
		$error("phy_read_cal_tracking_port: GROUPS must be 1 to 5");
	end
	if (LINK_CYCLES < 1 || LINK_CYCLES >= 2**CW || FIFO_CYCLES < 1 || FIFO_CYCLES >= 2**CW) begin : g_bad_cal
		$error("phy_read_cal_tracking_port: calibration counts out of range");
	end

	localparam logic [CW-1:0] LINK_LAST = CW'(LINK_CYCLES - 1);
	localparam logic [CW-1:0] FIFO_LAST = CW'(FIFO_CYCLES - 1);

	typedef enum logic [2:0] {
		REG_CTRL,
		REG_STATUS,
		REG_WLAT,
		REG_RLAT,
		REG_IRQ_STAT,
		REG_IRQ_MASK,
		REG_NONE
	} reg_sel_t;

	typedef struct packed {
		phy_cal_pkg::seq_state_t       st;
		logic [CW-1:0]                 cnt;
		logic                          success;
		logic                          fail;
		logic                          track_en;
		logic                          fail_inject;
		logic                          soft_recal;
		logic [WL-1:0]                 wlat;
		logic [phy_cal_pkg::LAT_W-1:0] rlat;
		logic [phy_cal_pkg::IRQ_W-1:0] irq_stat;
		logic [phy_cal_pkg::IRQ_W-1:0] irq_mask;
		logic                          loaded;
		logic [31:0]                   prdata;
		logic                          pslverr;
	} port_t;

	port_t s_r;
	port_t s_nxt;

	logic                             recal;
	logic                             acc_done;
	logic                             track_on;
	logic                             track_done;
	logic [phy_cal_pkg::TRACK_CH-1:0] busy_w;
	logic [phy_cal_pkg::IRQ_W-1:0]    ev;
	reg_sel_t                         wsel;

	// ==========================================
	// address decode
	function automatic reg_sel_t decode(input logic [7:0] a);
		unique case (a)
			phy_cal_pkg::CTRL_OFS:     decode = REG_CTRL;
			phy_cal_pkg::STATUS_OFS:   decode = REG_STATUS;
			phy_cal_pkg::WLAT_OFS:     decode = REG_WLAT;
			phy_cal_pkg::RLAT_OFS:     decode = REG_RLAT;
			phy_cal_pkg::IRQ_STAT_OFS: decode = REG_IRQ_STAT;
			phy_cal_pkg::IRQ_MASK_OFS: decode = REG_IRQ_MASK;
			default:                   decode = REG_NONE;
		endcase
	endfunction

	function automatic logic [31:0] read_word(input reg_sel_t sel, input port_t s,
			input logic [phy_cal_pkg::TRACK_CH-1:0] busy);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (sel)
			REG_CTRL: begin
				w[phy_cal_pkg::CTRL_TRACK_EN_BIT]    = s.track_en;
				w[phy_cal_pkg::CTRL_FAIL_INJECT_BIT] = s.fail_inject;
				w[phy_cal_pkg::CTRL_SOFT_RECAL_BIT]  = s.soft_recal;
			end
			REG_STATUS: begin
				w[phy_cal_pkg::STAT_SUCCESS_BIT] = s.success;
				w[phy_cal_pkg::STAT_FAIL_BIT]    = s.fail;
				w[phy_cal_pkg::STAT_RUNNING_BIT] = !s.success && !s.fail;
				w[phy_cal_pkg::STAT_BUSY_LSB +: phy_cal_pkg::TRACK_CH] = busy;
			end
			REG_WLAT:     w[WL-1:0]                 = s.wlat;
			REG_RLAT:     w[phy_cal_pkg::LAT_W-1:0] = s.rlat;
			REG_IRQ_STAT: w[phy_cal_pkg::IRQ_W-1:0] = s.irq_stat;
			REG_IRQ_MASK: w[phy_cal_pkg::IRQ_W-1:0] = s.irq_mask;
			REG_NONE:     w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	assign acc_done = psel && penable && s_r.loaded && ce;
	assign recal    = cal_req || s_r.soft_recal;
	assign track_on = s_r.success && s_r.track_en && !recal;
	assign wsel     = decode(paddr);

	// ==========================================
	// next state
	always_comb begin
		s_nxt = s_r;
		ev = '0;

		// read data and error captured before the access completes
		if (psel && !s_r.loaded) begin
			s_nxt.prdata  = read_word(wsel, s_r, busy_w);
			s_nxt.pslverr = (wsel == REG_NONE);
			s_nxt.loaded  = 1'b1;
		end
		if (acc_done) begin
			s_nxt.loaded = 1'b0;
		end

		unique case (s_r.st)
			phy_cal_pkg::SEQ_RESET: begin
				s_nxt.cnt = '0;
				s_nxt.st = phy_cal_pkg::SEQ_LINK;
			end
			phy_cal_pkg::SEQ_LINK: begin
				if (s_r.cnt == LINK_LAST) begin
					s_nxt.cnt = '0;
					s_nxt.st  = phy_cal_pkg::SEQ_FIFO;
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
				end
			end
			phy_cal_pkg::SEQ_FIFO: begin
				if (s_r.cnt == FIFO_LAST) begin
					s_nxt.cnt = '0;
					if (s_r.fail_inject) begin
						s_nxt.st = phy_cal_pkg::SEQ_FAIL;
						ev[phy_cal_pkg::IRQ_FAIL_BIT] = 1'b1;
					end else begin
						s_nxt.st = phy_cal_pkg::SEQ_PASS;
						ev[phy_cal_pkg::IRQ_PASS_BIT] = 1'b1;
					end
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
				end
			end
			phy_cal_pkg::SEQ_PASS: s_nxt.st = phy_cal_pkg::SEQ_PASS;
			phy_cal_pkg::SEQ_FAIL: s_nxt.st = phy_cal_pkg::SEQ_FAIL;
			default: begin
				s_nxt.st  = phy_cal_pkg::SEQ_RESET;
				s_nxt.cnt = '0;
			end
		endcase

		if (recal) begin
			s_nxt.st  = phy_cal_pkg::SEQ_RESET;
			s_nxt.cnt = '0;
			ev = '0;
		end

		s_nxt.success = (s_nxt.st == phy_cal_pkg::SEQ_PASS);
		s_nxt.fail = (s_nxt.st == phy_cal_pkg::SEQ_FAIL);

		ev[phy_cal_pkg::IRQ_TRACK_BIT] = track_done;

		// register writes
		if (acc_done && pwrite) begin
			unique case (wsel)
				REG_CTRL: begin
					s_nxt.track_en    = pwdata[phy_cal_pkg::CTRL_TRACK_EN_BIT];
					s_nxt.fail_inject = pwdata[phy_cal_pkg::CTRL_FAIL_INJECT_BIT];
					s_nxt.soft_recal  = pwdata[phy_cal_pkg::CTRL_SOFT_RECAL_BIT];
				end
				REG_WLAT:     s_nxt.wlat = pwdata[WL-1:0];
				REG_RLAT:     s_nxt.rlat = pwdata[phy_cal_pkg::LAT_W-1:0];
				REG_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~pwdata[phy_cal_pkg::IRQ_W-1:0];
				REG_IRQ_MASK: s_nxt.irq_mask = pwdata[phy_cal_pkg::IRQ_W-1:0];
				REG_STATUS, REG_NONE: s_nxt.irq_mask = s_r.irq_mask;
			endcase
		end
		// new events win over a clear in the same cycle
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r             <= '0;
			s_r.st          <= phy_cal_pkg::SEQ_RESET;
			s_r.track_en    <= phy_cal_pkg::CTRL_RST[phy_cal_pkg::CTRL_TRACK_EN_BIT];
			s_r.fail_inject <= phy_cal_pkg::CTRL_RST[phy_cal_pkg::CTRL_FAIL_INJECT_BIT];
			s_r.soft_recal  <= phy_cal_pkg::CTRL_RST[phy_cal_pkg::CTRL_SOFT_RECAL_BIT];
			s_r.wlat        <= {GROUPS{phy_cal_pkg::LAT_RST}};
			s_r.rlat        <= phy_cal_pkg::LAT_RST;
			s_r.irq_mask    <= phy_cal_pkg::IRQ_MASK_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// read return path
	phy_read_return #(
		.RATE       (RATE),
		.DQ         (DQ),
		.SINGLE_BIT (SINGLE_BIT)
	) u_read_return (
		.pclk          (pclk),
		.presetn       (presetn),
		.ce            (ce),
		.enable        (s_r.success),
		.rlat          (s_r.rlat),
		.rdata_en_full (rdata_en_full),
		.cap_rdata     (cap_rdata),
		.rdata_valid   (rdata_valid),
		.rdata         (rdata)
	);

	// ==========================================
	// tracking manager
	phy_track_mgr #(
		.INTERVAL (TRK_PERIOD),
		.DURATION (TRK_CYCLES)
	) u_track_mgr (
		.pclk             (pclk),
		.presetn          (presetn),
		.ce               (ce),
		.enable           (track_on),
		.ctl_refresh_done (ctl_refresh_done),
		.ctl_long_idle    (ctl_long_idle),
		.seq_busy         (busy_w),
		.track_done       (track_done)
	);

	// ==========================================
	// outputs
	assign prdata      = s_r.prdata;
	assign pready      = acc_done;
	assign pslverr     = acc_done && s_r.pslverr;
	assign irq         = |(s_r.irq_stat & s_r.irq_mask);
	assign cal_success = s_r.success;
	assign cal_fail    = s_r.fail;
	assign wlat        = s_r.wlat;
	// no read latency in phy-only build
	assign rlat        = PHY_ONLY ? '0 : s_r.rlat;
	assign seq_busy    = busy_w;
endmodule
`default_nettype wire

// ### phy_read_cal_tracking_port_tb.sv
`default_nettype none
module phy_read_cal_tracking_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int L = 4;
	localparam int F = 4;
	localparam int T = 3;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        cal_req = 1'b0;
	logic        rd_go = 1'b0;
	logic [7:0]  rd_len = 8'h00;
	logic [1:0]  hs_go = 2'h0;
	logic [1:0]  hs_ch = 2'h0;
	logic [31:0] prdata, rdata, cap_rdata, q;
	logic        pready, pslverr, irq, cal_success, cal_fail, e;
	logic [1:0]  rdata_valid, rdata_en_full;
	logic [23:0] wlat;
	logic [5:0]  rlat;
	logic [5:0]  rlat_b;
	logic [1:0]  rdata_valid_b;
	logic [3:0]  seq_busy, ctl_refresh_done, ctl_long_idle;
	logic [15:0] cyc;
	int          error_cnt = 0;
	int          compares = 0;
	int          ticks = 0;
	int          lats[3] = '{0, 2, 63};

	phy_read_cal_tracking_port #(.LINK_CYCLES(L), .FIFO_CYCLES(F), .TRK_CYCLES(T), .TRK_PERIOD(50))
	i_phy_read_cal_tracking_port (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.rdata_en_full(rdata_en_full), .cap_rdata(cap_rdata), .rdata(rdata), .rdata_valid(rdata_valid),
		.cal_success(cal_success), .cal_fail(cal_fail), .cal_req(cal_req), .wlat(wlat), .rlat(rlat),
		.ctl_refresh_done(ctl_refresh_done), .seq_busy(seq_busy), .ctl_long_idle(ctl_long_idle)
	);
	// single-bit enable and phy-only build, enable bit 1 left low on purpose
	phy_read_cal_tracking_port #(.LINK_CYCLES(L), .FIFO_CYCLES(F), .TRK_CYCLES(T), .TRK_PERIOD(50),
		.SINGLE_BIT(1'b1), .PHY_ONLY(1'b1))
	i_phy_read_cal_tracking_port_b (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .irq(),
		.rdata_en_full({1'b0, rdata_en_full[0]}), .cap_rdata(cap_rdata), .rdata(), .rdata_valid(rdata_valid_b),
		.cal_success(), .cal_fail(), .cal_req(cal_req), .wlat(), .rlat(rlat_b),
		.ctl_refresh_done(ctl_refresh_done), .seq_busy(), .ctl_long_idle(ctl_long_idle)
	);
	ctl_model i_ctl_model (
		.pclk(pclk), .presetn(presetn), .rd_go(rd_go), .rd_len(rd_len), .hs_go(hs_go), .hs_ch(hs_ch),
		.seq_busy(seq_busy), .rdata_en_full(rdata_en_full), .cap_rdata(cap_rdata),
		.ctl_refresh_done(ctl_refresh_done), .ctl_long_idle(ctl_long_idle), .cyc(cyc)
	);

	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		ticks <= ticks + 1;
		if (ticks == 4000) begin
			error_cnt = error_cnt + 1;
			wrap_up();
		end
	end

	// ==========================================
	// tasks
	task automatic wrap_up();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic cal_wait(input logic es, input logic ef);
		step(L + F);
		chk({30'h0, cal_success, cal_fail}, 32'h0);
		step(1);
		chk({30'h0, cal_success, cal_fail}, {30'h0, es, ef});
	endtask
	task automatic burst(input int l);
		logic [15:0] s;
		@(posedge pclk);
		rd_len <= 8'h02;
		rd_go <= 1'b1;
		@(posedge pclk);
		rd_go <= 1'b0;
		#1;
		s = cyc;
		step(l);
		chk({28'h0, rdata_valid_b, rdata_valid}, 32'h0);
		step(1);
		chk({28'h0, rdata_valid_b, rdata_valid}, 32'hf);
		chk(rdata, {16'hda7a, 16'(s + l)});
		step(1);
		chk(rdata, {16'hda7a, 16'(s + l + 1)});
		step(1);
		chk({28'h0, rdata_valid_b, rdata_valid}, 32'h0);
	endtask
	task automatic trk(input int ch, input logic [1:0] kind);
		int n = 0;
		int len = 0;
		while (seq_busy[ch] !== 1'b0)
			step(1);
		@(posedge pclk);
		hs_ch <= 2'(ch);
		hs_go <= kind;
		@(posedge pclk);
		hs_go <= 2'h0;
		#1;
		while (seq_busy[ch] !== 1'b1 && n < 30) begin
			step(1);
			n++;
		end
		while (seq_busy[ch] === 1'b1 && len < 30) begin
			step(1);
			len++;
		end
		chk(32'(len), T);
	endtask

	// ==========================================
	// sequence
	initial begin
		int n;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		cal_wait(1'b1, 1'b0);
		rd(phy_cal_pkg::STATUS_OFS, 32'h1);
		rd(phy_cal_pkg::CTRL_OFS, 32'h0);
		rd(phy_cal_pkg::WLAT_OFS, 32'h0);
		rd(phy_cal_pkg::RLAT_OFS, 32'h0);
		rd(phy_cal_pkg::IRQ_MASK_OFS, 32'h0);
		rd(8'h20, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, phy_cal_pkg::STATUS_OFS, 32'h0);
		rd(phy_cal_pkg::STATUS_OFS, 32'h1);
		rd(phy_cal_pkg::IRQ_STAT_OFS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, phy_cal_pkg::IRQ_MASK_OFS, 32'h7);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, phy_cal_pkg::IRQ_STAT_OFS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, phy_cal_pkg::CTRL_OFS, 32'h2);
		@(posedge pclk);
		cal_req <= 1'b1;
		step(3);
		chk({30'h0, cal_success, cal_fail}, 32'h0);
		@(posedge pclk);
		cal_req <= 1'b0;
		cal_wait(1'b0, 1'b1);
		rd(phy_cal_pkg::STATUS_OFS, 32'h2);
		rd(phy_cal_pkg::IRQ_STAT_OFS, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, phy_cal_pkg::CTRL_OFS, 32'h4);
		rd(phy_cal_pkg::STATUS_OFS, 32'h4);
		apb(1'b1, phy_cal_pkg::CTRL_OFS, 32'h0);
		cal_wait(1'b1, 1'b0);
		apb(1'b1, phy_cal_pkg::IRQ_STAT_OFS, 32'h7);
		apb(1'b1, phy_cal_pkg::WLAT_OFS, 32'hfffc_3f81);
		rd(phy_cal_pkg::WLAT_OFS, 32'h00fc_3f81);
		chk({8'h00, wlat}, 32'h00fc_3f81);
		foreach (lats[i]) begin
			apb(1'b1, phy_cal_pkg::RLAT_OFS, 32'(lats[i]));
			chk({26'h0, rlat}, 32'(lats[i]));
			chk({26'h0, rlat_b}, 32'h0);
			burst(lats[i]);
		end
		apb(1'b1, phy_cal_pkg::IRQ_MASK_OFS, 32'h4);
		apb(1'b1, phy_cal_pkg::CTRL_OFS, 32'h1);
		trk(0, 2'b01);
		trk(1, 2'b10);
		while (seq_busy !== 4'hf && n < 150) begin
			step(1);
			n++;
		end
		chk({28'h0, seq_busy}, 32'hf);
		rd(phy_cal_pkg::IRQ_STAT_OFS, 32'h4);
		chk({31'h0, irq}, 32'h1);
		@(posedge pclk);
		cal_req <= 1'b1;
		step(2);
		chk({28'h0, seq_busy}, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire

// ### phy_read_return.sv
`default_nettype none
module phy_read_return #(
	parameter int RATE       = 2,
	parameter int DQ         = 32,
	parameter bit SINGLE_BIT = 1'b0
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          ce,
	input  wire logic                          enable,
	input  wire logic [phy_cal_pkg::LAT_W-1:0] rlat,
	input  wire logic [RATE-1:0]               rdata_en_full,
	input  wire logic [DQ-1:0]                 cap_rdata,
	output logic      [RATE-1:0]               rdata_valid,
	output logic      [DQ-1:0]                 rdata
);
	localparam int DEPTH = phy_cal_pkg::LAT_MAX + 1;

	if (RATE < 1 || RATE > 4 || DQ < 1) begin : g_bad
		$error("phy_read_return: unsupported RATE or DQ");
	end

	typedef struct packed {
		logic [DEPTH-1:0][RATE-1:0] pipe;
		logic [RATE-1:0]            valid;
		logic [DQ-1:0]              data;
	} rr_t;

	rr_t s_r;
	rr_t s_nxt;
	logic [RATE-1:0] en_eff;

	always_comb begin
		s_nxt = s_r;
		en_eff = SINGLE_BIT ? {RATE{rdata_en_full[0]}} : rdata_en_full;
		en_eff = en_eff & {RATE{enable}};
		s_nxt.pipe[0] = en_eff;
		for (int k = 1; k < DEPTH; k++) begin
			s_nxt.pipe[k] = s_r.pipe[k-1];
		end
		if (rlat == '0) begin
			s_nxt.valid = en_eff;
		end else begin
			s_nxt.valid = s_r.pipe[rlat - 6'h01];
		end
		if (SINGLE_BIT) begin
			s_nxt.valid = {RATE{s_nxt.valid[0]}};
		end
		if (|s_nxt.valid) begin
			s_nxt.data = cap_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign rdata_valid = s_r.valid;
	assign rdata       = s_r.data;
endmodule
`default_nettype wire

// ### phy_track_mgr.sv
`default_nettype none
module phy_track_mgr #(
	parameter int INTERVAL = phy_cal_pkg::TRACK_INTERVAL,
	parameter int DURATION = phy_cal_pkg::TRACK_CYCLES
) (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	input  wire logic                             ce,
	input  wire logic                             enable,
	input  wire logic [phy_cal_pkg::TRACK_CH-1:0] ctl_refresh_done,
	input  wire logic [phy_cal_pkg::TRACK_CH-1:0] ctl_long_idle,
	output logic      [phy_cal_pkg::TRACK_CH-1:0] seq_busy,
	output logic                                  track_done
);
	localparam int CH = phy_cal_pkg::TRACK_CH;
	localparam int CW = phy_cal_pkg::CNT_W;

	if (INTERVAL < 2 || INTERVAL >= 2**CW || DURATION < 1 || DURATION >= 2**CW) begin : g_bad
		$error("phy_track_mgr: INTERVAL or DURATION out of range");
	end

	localparam logic [CW-1:0] INT_LAST = CW'(INTERVAL - 1);
	localparam logic [CW-1:0] DUR_LAST = CW'(DURATION - 1);

	typedef struct packed {
		logic [CW-1:0]         tick;
		logic [CH-1:0]         busy;
		logic [CH-1:0][CW-1:0] cnt;
		logic                  done;
	} tm_t;

	tm_t  s_r;
	tm_t  s_nxt;
	logic due;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		due = 1'b0;
		if (!enable) begin
			s_nxt.tick = '0;
		end else if (s_r.tick == INT_LAST) begin
			s_nxt.tick = '0;
			due = 1'b1;
		end else begin
			s_nxt.tick = s_r.tick + 1'b1;
		end
		for (int i = 0; i < CH; i++) begin
			if (!enable) begin
				s_nxt.busy[i] = 1'b0;
				s_nxt.cnt[i]  = '0;
			end else if (s_r.busy[i]) begin
				if (s_r.cnt[i] == DUR_LAST) begin
					s_nxt.busy[i] = 1'b0;
					s_nxt.cnt[i]  = '0;
					s_nxt.done    = 1'b1;
				end else begin
					s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
				end
			end else if (due || ctl_refresh_done[i] || ctl_long_idle[i]) begin
				s_nxt.busy[i] = 1'b1;
				s_nxt.cnt[i]  = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign seq_busy   = s_r.busy;
	assign track_done = s_r.done;
endmodule
`default_nettype wire
